// file: design/bsb_pkg.sv
package bsb_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int BAUD_MIN_BPS = 1200;
  localparam int BAUD_MAX_BPS = 500_000;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_115200 = 115_200;
  localparam int BAUD_460800 = 460_800;
  localparam int BRK_MAX_MS = 65534;

  // Bit periods in clk cycles, rounded to the nearest cycle
  localparam logic [15:0] DIV_9600 = 16'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
  localparam logic [15:0] DIV_115200 = 16'((CLK_HZ + BAUD_115200 / 2) / BAUD_115200);
  localparam logic [15:0] DIV_460800 = 16'((CLK_HZ + BAUD_460800 / 2) / BAUD_460800);
  localparam logic [15:0] BIT_CYC_MIN = 16'((CLK_HZ + BAUD_MAX_BPS / 2) / BAUD_MAX_BPS);
  localparam int BIT_CYC_MAX_I = (CLK_HZ + BAUD_MIN_BPS / 2) / BAUD_MIN_BPS;
  localparam int MS_CYC_I = CLK_HZ / MS_PER_S;
  localparam int BRK_BITS_I = 11;
  localparam int BRK_CAP_CYC_I = BRK_BITS_I * BIT_CYC_MAX_I;

  localparam logic [3:0] BRK_BITS = 4'hB;
  localparam logic [15:0] BRK_INDEF = 16'hFFFF;
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic [6:0] FRAME_BYTES = 7'h40;
  localparam logic [2:0] TX_SLOTS = 3'h4;
  localparam logic [3:0] RX_SLOTS = 4'h8;
  localparam int TQ_AW = 8;
  localparam int RQ_AW = 9;
  localparam int FLUSH_MS = 100;
  localparam int SOF_PER_MS = 1;
  localparam logic [6:0] FLUSH_SOFS = 7'(FLUSH_MS * SOF_PER_MS);
  localparam logic [5:0] LEGACY_MAX = 6'h32;
  localparam logic [7:0] NUL_CHAR = 8'h00;

  // Command prefixes, right-justified; index 0 is the default send command
  localparam logic [3:0][127:0] PFX_TAB = {
    128'("CMD:SEND_460800="), 128'("CMD:SEND_115200="),
    128'("CMD:SEND_9600="), 128'("CMD:SEND_UART=")};
  localparam logic [3:0][4:0] PFX_LEN = {5'h10, 5'h10, 5'h0E, 5'h0E};
  localparam logic [3:0] CAND_ALL = 4'hF;
  localparam logic [3:0] CAND_DEFAULT = 4'h1;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_LOAD = 3'b001, TX_SHIFT = 3'b010, TX_BREAK = 3'b011, TX_GAP = 3'b100
  } bsb_tx_st_t;
  typedef enum logic [1:0] {
    OV_IDLE = 2'b00, OV_MATCH = 2'b01, OV_SEND = 2'b10, OV_DRAIN = 2'b11
  } bsb_ovr_st_t;
  typedef enum logic [1:0] {
    RATE_CFG = 2'b00, RATE_9600 = 2'b01, RATE_115200 = 2'b10, RATE_460800 = 2'b11
  } bsb_rate_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } bsb_rx_st_t;

  function automatic logic [7:0] bsb_pfx_byte(input int c, input logic [4:0] idx);
    int sh;
    sh = (int'(PFX_LEN[c]) - 1 - int'(idx)) * 8;
    if (sh < 0)
    begin
      return NUL_CHAR;
    end
    return PFX_TAB[c][sh +: 8];
  endfunction : bsb_pfx_byte

  function automatic logic [15:0] bsb_rate_div(input bsb_rate_t r, input logic [15:0] cfg);
    unique case (r)
      RATE_9600: return DIV_9600;
      RATE_115200: return DIV_115200;
      RATE_460800: return DIV_460800;
      RATE_CFG: return cfg;
    endcase
  endfunction : bsb_rate_div
endpackage : bsb_pkg

// file: design/bsb_mem_if.sv
`timescale 1ns/1ps
interface bsb_mem_if #(parameter int AW = 8);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : bsb_mem_if

// file: design/bsb_mem.sv
`timescale 1ns/1ps
module bsb_mem import bsb_pkg::*; #(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst,
  bsb_mem_if.mem port
);
  localparam int DEPTH = 1 << AW;
  typedef struct packed {
    logic [DEPTH-1:0][7:0] cells;
    logic [7:0] rdata;
  } bsb_mem_reg_t;
  bsb_mem_reg_t s_reg;
  bsb_mem_reg_t s_next;

  // Read data always comes one cycle after the address
  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = s_reg.cells[port.raddr];
    if (port.we)
    begin
      s_next.cells[port.waddr] = port.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign port.rdata = s_reg.rdata;
endmodule : bsb_mem

// file: design/bsb_rx.sv
`timescale 1ns/1ps
module bsb_rx import bsb_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic line,
  input wire logic [15:0] bit_cycles,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  typedef struct packed {
    bsb_rx_st_t st;
    logic [15:0] cnt;
    logic [2:0] bits;
    logic [7:0] data;
    logic valid;
  } bsb_rx_reg_t;
  bsb_rx_reg_t s_reg;
  bsb_rx_reg_t s_next;

  // Start edge is confirmed at half a bit, so later samples fall mid-bit
  always_comb
  begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    s_next.cnt = s_reg.cnt + 16'h1;
    unique case (s_reg.st)
      RX_IDLE:
      begin
        s_next.cnt = 16'h0;
        if (!line)
        begin
          s_next.st = RX_START;
        end
      end
      RX_START:
      begin
        if (s_reg.cnt == {1'b0, bit_cycles[15:1]})
        begin
          s_next.cnt = 16'h0;
          s_next.bits = 3'h0;
          s_next.st = line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA:
      begin
        if (s_reg.cnt == bit_cycles - 16'h1)
        begin
          s_next.cnt = 16'h0;
          s_next.data = {line, s_reg.data[7:1]};
          s_next.bits = s_reg.bits + 3'h1;
          if (s_reg.bits == 3'h7)
          begin
            s_next.st = RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        if (s_reg.cnt == bit_cycles - 16'h1)
        begin
          s_next.st = RX_IDLE;
          s_next.valid = line;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign byte_valid = s_reg.valid;
  assign byte_data = s_reg.data;
endmodule : bsb_rx

// file: design/bsb_bridge.sv
// Operation
// - Command-prefixed file text goes out serial output
// - Legacy override sends at most fifty characters
// - Legacy override uses 9600 unless session configured
// - Newer override accepts full storage frame payload
// - Newer override stops at first NULL character
// - Newer default send command always uses 9600
// - Terminal session suspended during override, then resumed
// - Host data queued as whole frames
// - Four outbound frames at most; host throttled
// - Full 64-byte receive frame queued to host
// - Partial receive frame flushed every 100 SOFs
// - Eight receive frames active at most
// - Overrun recycles newest frame, losing its data
// - Break drives at least eleven zero bits
// - Break start discards character being sent
// - Timed break capped at eleven slowest bits
// - Bit period clamped to supported baud range
// - Explicit-rate commands use 9600, 115200, 460800
// - Host data accepted and receive data queued only with DTR
`timescale 1ns/1ps
module bsb_bridge import bsb_pkg::*; #(
  parameter int MS_CYC = MS_CYC_I,
  parameter int BRK_CAP_CYC = BRK_CAP_CYC_I,
  parameter int BIT_CYC_MAX = BIT_CYC_MAX_I
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic dtr,
  input wire logic cdc_configured,
  input wire logic [15:0] cfg_bit_cycles,
  input wire logic sof,
  input wire logic h2t_valid,
  input wire logic [7:0] h2t_data,
  input wire logic h2t_last,
  output logic h2t_ready,
  output logic t2h_valid,
  output logic [7:0] t2h_data,
  output logic t2h_last,
  input wire logic t2h_ready,
  input wire logic ovr_valid,
  input wire logic [7:0] ovr_data,
  input wire logic ovr_last,
  input wire logic ovr_legacy,
  output logic ovr_ready,
  output logic ovr_busy,
  input wire logic brk_start,
  input wire logic [15:0] brk_ms,
  input wire logic brk_release,
  output logic brk_active,
  output logic rx_overrun,
  input wire logic bridge_serial_in,
  output logic bridge_serial_out
);
  typedef struct packed {
    logic sin_meta;
    logic sin_sync;
    bsb_tx_st_t tx_st;
    bsb_rate_t tx_rate;
    logic [15:0] baud_cnt;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic sout;
    logic brk_on;
    logic brk_indef;
    logic [15:0] brk_ms_left;
    logic [15:0] ms_cnt;
    logic [3:0] brk_bits;
    logic [19:0] cap_cnt;
    logic [1:0] tq_wr;
    logic [1:0] tq_rd;
    logic [2:0] tq_cnt;
    logic [6:0] tq_fill;
    logic [6:0] tq_pos;
    logic [3:0][6:0] tq_len;
    logic h2t_ready;
    bsb_ovr_st_t ov_st;
    bsb_rate_t ov_rate;
    logic ov_legacy;
    logic [7:0] ov_hold;
    logic ov_hold_v;
    logic ov_hold_last;
    logic [4:0] ov_idx;
    logic [3:0] ov_cand;
    logic [5:0] ov_sent;
    logic ovr_ready;
    logic ovr_busy;
    logic [2:0] rq_wr;
    logic [2:0] rq_rd;
    logic [3:0] rq_cnt;
    logic [6:0] rq_fill;
    logic [6:0] rq_pos;
    logic [7:0][6:0] rq_len;
    logic [6:0] sof_cnt;
    logic rd_pend;
    logic t2h_valid;
    logic [7:0] t2h_data;
    logic t2h_last;
    logic overrun;
  } bsb_top_reg_t;
  bsb_top_reg_t s_reg;
  bsb_top_reg_t s_next;

  bsb_mem_if #(.AW(TQ_AW)) tq_if ();
  bsb_mem_if #(.AW(RQ_AW)) rq_if ();
  logic rx_valid;
  logic [7:0] rx_byte;
  logic [15:0] cfg_div;
  logic [15:0] cur_div;
  logic tick;
  logic ov_active;
  logic tq_enq;
  logic tq_deq;
  logic rq_enq;
  logic rq_deq;
  logic flush;
  logic hit;
  logic brk_end;
  logic [3:0] alive;
  bsb_rate_t hit_rate;
  logic [6:0] fill_a;

  bsb_mem #(.AW(TQ_AW)) u_tq_mem (.clk(clk), .rst(rst), .port(tq_if.mem));
  bsb_mem #(.AW(RQ_AW)) u_rq_mem (.clk(clk), .rst(rst), .port(rq_if.mem));
  bsb_rx u_rx (
    .clk(clk),
    .rst(rst),
    .line(s_reg.sin_sync),
    .bit_cycles(cfg_div),
    .byte_valid(rx_valid),
    .byte_data(rx_byte)
  );

  always_comb
  begin
    s_next = s_reg;
    s_next.sin_meta = bridge_serial_in;
    s_next.sin_sync = s_reg.sin_meta;
    s_next.overrun = 1'b0;
    // Out-of-range settings are clamped silently
    cfg_div = cfg_bit_cycles;
    if (cfg_bit_cycles < BIT_CYC_MIN)
    begin
      cfg_div = BIT_CYC_MIN;
    end
    else if (cfg_bit_cycles > 16'(BIT_CYC_MAX))
    begin
      cfg_div = 16'(BIT_CYC_MAX);
    end
    cur_div = (s_reg.tx_st == TX_SHIFT) ? bsb_rate_div(s_reg.tx_rate, cfg_div) : cfg_div;
    tick = (s_reg.baud_cnt == cur_div - 16'h1);
    s_next.baud_cnt = tick ? 16'h0 : s_reg.baud_cnt + 16'h1;
    ov_active = (s_reg.ov_st != OV_IDLE);
    tq_enq = 1'b0;
    tq_deq = 1'b0;
    rq_enq = 1'b0;
    rq_deq = 1'b0;
    flush = 1'b0;
    hit = 1'b0;
    alive = 4'h0;
    hit_rate = RATE_9600;
    brk_end = 1'b0;
    tq_if.we = 1'b0;
    tq_if.waddr = {s_reg.tq_wr, s_reg.tq_fill[5:0]};
    tq_if.wdata = h2t_data;
    tq_if.raddr = {s_reg.tq_rd, s_reg.tq_pos[5:0]};
    rq_if.we = 1'b0;
    rq_if.waddr = {s_reg.rq_wr, s_reg.rq_fill[5:0]};
    rq_if.wdata = rx_byte;
    rq_if.raddr = {s_reg.rq_rd, s_reg.rq_pos[5:0]};

    // Host bytes fill one slot; a frame is queued only when it closes
    if (s_reg.h2t_ready && h2t_valid)
    begin
      tq_if.we = 1'b1;
      s_next.tq_fill = s_reg.tq_fill + 7'h1;
      if (h2t_last || s_next.tq_fill == FRAME_BYTES)
      begin
        s_next.tq_len[s_reg.tq_wr] = s_next.tq_fill;
        s_next.tq_wr = s_reg.tq_wr + 2'h1;
        s_next.tq_fill = 7'h0;
        tq_enq = 1'b1;
      end
    end

    unique case (s_reg.tx_st)
      TX_IDLE:
      begin
        s_next.sout = 1'b1;
        // Queue stays parked while an override owns the line
        if (s_reg.tq_cnt != 3'h0 && !ov_active)
        begin
          s_next.tx_st = TX_LOAD;
        end
      end
      TX_LOAD:
      begin
        s_next.tx_st = TX_SHIFT;
        s_next.tx_rate = RATE_CFG;
        s_next.shift = {1'b1, tq_if.rdata};
        s_next.sout = 1'b0;
        s_next.baud_cnt = 16'h0;
        s_next.bit_cnt = 4'h0;
        s_next.tq_pos = s_reg.tq_pos + 7'h1;
        if (s_next.tq_pos == s_reg.tq_len[s_reg.tq_rd])
        begin
          s_next.tq_pos = 7'h0;
          s_next.tq_rd = s_reg.tq_rd + 2'h1;
          tq_deq = 1'b1;
        end
      end
      TX_SHIFT:
      begin
        if (tick)
        begin
          if (s_reg.bit_cnt == STOP_IDX)
          begin
            s_next.tx_st = TX_IDLE;
            s_next.sout = 1'b1;
          end
          else
          begin
            s_next.sout = s_reg.shift[0];
            s_next.shift = {1'b1, s_reg.shift[8:1]};
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end
        end
      end
      TX_BREAK:
      begin
        s_next.sout = 1'b0;
        if (tick && s_reg.brk_bits != BRK_BITS)
        begin
          s_next.brk_bits = s_reg.brk_bits + 4'h1;
        end
        s_next.ms_cnt = s_reg.ms_cnt + 16'h1;
        if (s_reg.ms_cnt == 16'(MS_CYC - 1))
        begin
          s_next.ms_cnt = 16'h0;
          if (s_reg.brk_ms_left != 16'h0)
          begin
            s_next.brk_ms_left = s_reg.brk_ms_left - 16'h1;
          end
        end
        if (s_reg.cap_cnt != 20'(BRK_CAP_CYC))
        begin
          s_next.cap_cnt = s_reg.cap_cnt + 20'h1;
        end
        // Never shorter than eleven bits timed breaks capped
        if (s_reg.brk_indef)
        begin
          brk_end = brk_release;
        end
        else
        begin
          brk_end = brk_release || s_reg.brk_ms_left == 16'h0 ||
                    s_reg.cap_cnt == 20'(BRK_CAP_CYC);
        end
        if (brk_end && s_reg.brk_bits == BRK_BITS)
        begin
          s_next.tx_st = TX_GAP;
          s_next.sout = 1'b1;
          s_next.baud_cnt = 16'h0;
        end
      end
      TX_GAP:
      begin
        // One idle bit before any new start bit
        s_next.sout = 1'b1;
        if (tick)
        begin
          s_next.tx_st = TX_IDLE;
        end
      end
      default:
      begin
        s_next.tx_st = TX_IDLE;
        s_next.sout = 1'b1;
      end
    endcase

    unique case (s_reg.ov_st)
      OV_IDLE:
      begin
        if (s_reg.ov_hold_v)
        begin
          s_next.ov_st = OV_MATCH;
          s_next.ov_idx = 5'h0;
          s_next.ov_sent = 6'h0;
          s_next.ov_legacy = ovr_legacy;
          s_next.ov_cand = ovr_legacy ? CAND_DEFAULT : CAND_ALL;
        end
      end
      OV_MATCH:
      begin
        if (s_reg.ov_hold_v)
        begin
          s_next.ov_hold_v = 1'b0;
          s_next.ov_idx = s_reg.ov_idx + 5'h1;
          // File name is never looked at, only its leading text
          for (int c = 0; c < 4; c++)
          begin
            if (s_reg.ov_cand[c] && s_reg.ov_hold == bsb_pfx_byte(c, s_reg.ov_idx))
            begin
              alive[c] = 1'b1;
              if (s_reg.ov_idx + 5'h1 == PFX_LEN[c])
              begin
                hit = 1'b1;
                hit_rate = bsb_rate_t'(c[1:0]);
              end
            end
          end
          // Default command: 9600 unless a legacy session is configured
          if (hit && alive[0])
          begin
            hit_rate = (s_reg.ov_legacy && (dtr || cdc_configured)) ? RATE_CFG : RATE_9600;
          end
          s_next.ov_cand = alive;
          s_next.ov_rate = hit_rate;
          if (s_reg.ov_hold_last)
          begin
            s_next.ov_st = OV_IDLE;
          end
          else if (hit)
          begin
            s_next.ov_st = OV_SEND;
          end
          else if (alive == 4'h0)
          begin
            s_next.ov_st = OV_DRAIN;
          end
        end
      end
      OV_SEND:
      begin
        // Streamed byte by byte; only legacy overrides stop at LEGACY_MAX bytes
        if (s_reg.ov_hold_v && s_reg.tx_st == TX_IDLE)
        begin
          s_next.ov_hold_v = 1'b0;
          if (!s_reg.ov_legacy && s_reg.ov_hold == NUL_CHAR)
          begin
            s_next.ov_st = s_reg.ov_hold_last ? OV_IDLE : OV_DRAIN;
          end
          else
          begin
            s_next.tx_st = TX_SHIFT;
            s_next.tx_rate = s_reg.ov_rate;
            s_next.shift = {1'b1, s_reg.ov_hold};
            s_next.sout = 1'b0;
            s_next.baud_cnt = 16'h0;
            s_next.bit_cnt = 4'h0;
            s_next.ov_sent = s_reg.ov_sent + 6'h1;
            if (s_reg.ov_hold_last)
            begin
              s_next.ov_st = OV_IDLE;
            end
            else if (s_reg.ov_legacy && s_next.ov_sent == LEGACY_MAX)
            begin
              s_next.ov_st = OV_DRAIN;
            end
          end
        end
      end
      OV_DRAIN:
      begin
        if (s_reg.ov_hold_v)
        begin
          s_next.ov_hold_v = 1'b0;
          if (s_reg.ov_hold_last)
          begin
            s_next.ov_st = OV_IDLE;
          end
        end
      end
    endcase
    if (s_reg.ovr_ready && ovr_valid)
    begin
      s_next.ov_hold = ovr_data;
      s_next.ov_hold_v = 1'b1;
      s_next.ov_hold_last = ovr_last;
    end
    s_next.ovr_ready = !s_next.ov_hold_v;
    s_next.ovr_busy = (s_next.ov_st != OV_IDLE);

    // Break wins over everything and drops the character in flight
    if (brk_start)
    begin
      s_next.tx_st = TX_BREAK;
      s_next.sout = 1'b0;
      s_next.baud_cnt = 16'h0;
      s_next.brk_bits = 4'h0;
      s_next.ms_cnt = 16'h0;
      s_next.cap_cnt = 20'h0;
      s_next.brk_ms_left = brk_ms;
      s_next.brk_indef = (brk_ms == BRK_INDEF);
    end
    s_next.brk_on = (s_next.tx_st == TX_BREAK);

    // Receive side gated by DTR and by an override
    fill_a = s_reg.rq_fill;
    if (rx_valid && dtr && !ov_active)
    begin
      rq_if.we = 1'b1;
      fill_a = s_reg.rq_fill + 7'h1;
    end
    if (sof)
    begin
      s_next.sof_cnt = s_reg.sof_cnt + 7'h1;
      if (s_reg.sof_cnt == FLUSH_SOFS - 7'h1)
      begin
        s_next.sof_cnt = 7'h0;
        flush = 1'b1;
      end
    end
    s_next.rq_fill = fill_a;
    if (fill_a == FRAME_BYTES || (flush && fill_a != 7'h0))
    begin
      s_next.rq_fill = 7'h0;
      // Filling slot plus queued frames never pass eight
      if (s_reg.rq_cnt < RX_SLOTS - 4'h1)
      begin
        s_next.rq_len[s_reg.rq_wr] = fill_a;
        s_next.rq_wr = s_reg.rq_wr + 3'h1;
        rq_enq = 1'b1;
      end
      else
      begin
        s_next.overrun = 1'b1;
      end
    end

    // Memory read latency is one cycle, so each byte to the host takes two
    if (s_reg.t2h_valid && t2h_ready)
    begin
      s_next.t2h_valid = 1'b0;
    end
    if (s_reg.rd_pend)
    begin
      s_next.rd_pend = 1'b0;
      s_next.t2h_valid = 1'b1;
      s_next.t2h_data = rq_if.rdata;
      s_next.rq_pos = s_reg.rq_pos + 7'h1;
      s_next.t2h_last = (s_next.rq_pos == s_reg.rq_len[s_reg.rq_rd]);
      if (s_next.t2h_last)
      begin
        s_next.rq_pos = 7'h0;
        s_next.rq_rd = s_reg.rq_rd + 3'h1;
        rq_deq = 1'b1;
      end
    end
    else if ((!s_reg.t2h_valid || t2h_ready) && s_reg.rq_cnt != 4'h0)
    begin
      s_next.rd_pend = 1'b1;
    end

    s_next.tq_cnt = s_reg.tq_cnt + {2'h0, tq_enq} - {2'h0, tq_deq};
    s_next.rq_cnt = s_reg.rq_cnt + {3'h0, rq_enq} - {3'h0, rq_deq};
    // Host throttled while all four slots hold frames
    s_next.h2t_ready = dtr && (s_next.ov_st == OV_IDLE) && (s_next.tq_cnt < TX_SLOTS);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.sin_meta <= 1'b1;
      s_reg.sin_sync <= 1'b1;
      s_reg.sout <= 1'b1;
      s_reg.ovr_ready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign h2t_ready = s_reg.h2t_ready;
  assign t2h_valid = s_reg.t2h_valid;
  assign t2h_data = s_reg.t2h_data;
  assign t2h_last = s_reg.t2h_last;
  assign ovr_ready = s_reg.ovr_ready;
  assign ovr_busy = s_reg.ovr_busy;
  assign brk_active = s_reg.brk_on;
  assign rx_overrun = s_reg.overrun;
  assign bridge_serial_out = s_reg.sout;
endmodule : bsb_bridge

// file: sim/bsb_monitor.sv
`timescale 1ns/1ps
module bsb_monitor import bsb_pkg::*; #(
  parameter int BRK_CAP_CYC = BRK_CAP_CYC_I
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic dtr,
  input wire logic [15:0] cfg_bit_cycles,
  input wire logic h2t_ready,
  input wire logic t2h_valid,
  input wire logic [7:0] t2h_data,
  input wire logic t2h_last,
  input wire logic t2h_ready,
  input wire logic brk_start,
  input wire logic [15:0] brk_ms,
  input wire logic brk_release,
  input wire logic brk_active,
  input wire logic bridge_serial_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] brk_cnt_reg;
  logic brk_ind_reg;
  // Restarted by a fresh request, as the break timing is
  always_ff @(posedge clk)
  begin
    if (rst || brk_start || !brk_active)
      brk_cnt_reg <= 32'h0;
    else
      brk_cnt_reg <= brk_cnt_reg + 32'h1;
    if (brk_start)
      brk_ind_reg <= (brk_ms == BRK_INDEF);
  end
  sequence s_brk_low;
    brk_active && !bridge_serial_out;
  endsequence
  sequence s_brk_idle;
    !brk_active && bridge_serial_out;
  endsequence
  chk_brk_enter: assert property (brk_start |=> s_brk_low)
    else $error("break not entered");
  chk_brk_hold: assert property (brk_active |-> !bridge_serial_out)
    else $error("line high during break");
  chk_brk_exit: assert property ($fell(brk_active) |-> s_brk_idle[*8])
    else $error("no idle after break");
  chk_brk_min: assert property ($fell(brk_active) |->
    brk_cnt_reg >= 32'(BRK_BITS) * 32'(cfg_bit_cycles))
    else $error("break too short");
  chk_brk_cap: assert property (brk_active && !brk_ind_reg |->
    brk_cnt_reg <= 32'(BRK_CAP_CYC + 2))
    else $error("timed break too long");
  chk_brk_release: assert property (brk_release && brk_active && brk_ind_reg &&
    brk_cnt_reg > 32'(BRK_BITS) * 32'(cfg_bit_cycles) |-> ##[1:2] !brk_active)
    else $error("release ignored");
  chk_h2t_dtr: assert property (!dtr |=> !h2t_ready)
    else $error("host data taken without session");
  chk_t2h_hold: assert property (t2h_valid && !t2h_ready |=>
    t2h_valid && $stable(t2h_data) && $stable(t2h_last))
    else $error("receive byte not held");
endmodule : bsb_monitor
bind bsb_bridge bsb_monitor #(.BRK_CAP_CYC(BRK_CAP_CYC)) i_mon (.*);

// file: sim/bsb_target.sv
`timescale 1ns/1ps
module bsb_target (
  input wire logic clk,
  input wire logic [15:0] bit_cyc,
  input wire logic rx_line,
  output logic tx_line
);
  logic [7:0] got_q[$];
  initial tx_line = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++)
    begin
      tx_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      repeat (bit_cyc) @(posedge clk);
    end
  endtask : send_byte
  // A bad stop bit (break) is not stored, like a real receiver
  initial
  begin
    logic [7:0] b;
    forever
    begin
      @(negedge rx_line);
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (bit_cyc) @(posedge clk);
        if (i < 8)
          b[i] = rx_line;
        else if (rx_line)
          got_q.push_back(b);
      end
    end
  end
endmodule : bsb_target

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench import bsb_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dtr = 1'b0;
  logic cdc_configured = 1'b0;
  logic [15:0] cfg_bit_cycles = 16'h0028;
  logic [15:0] bit_cyc = 16'h0028;
  logic [15:0] brk_ms = 16'h0000;
  logic [7:0] h2t_data = 8'h00, ovr_data = 8'h00, b, t2h_data;
  logic sof = 1'b0, sof_en = 1'b0, h2t_valid = 1'b0, h2t_last = 1'b0, t2h_ready = 1'b0;
  logic ovr_valid = 1'b0, ovr_last = 1'b0, ovr_legacy = 1'b0, brk_start = 1'b0;
  logic brk_release = 1'b0;
  logic h2t_ready, t2h_valid, t2h_last, ovr_ready, ovr_busy, brk_active, rx_overrun;
  logic bridge_serial_in, bridge_serial_out;
  logic [31:0] seed = 32'h0000001D;
  int err_total = 0, cmp_count = 0, cyc = 0, drops = 0, stalls = 0, n, lo;
  logic [7:0] exp_q[$];
  bsb_bridge #(.MS_CYC(50), .BRK_CAP_CYC(2200), .BIT_CYC_MAX(200)) i_dut (.*);
  bsb_target i_tgt (.clk(clk), .bit_cyc(bit_cyc), .rx_line(bridge_serial_out),
    .tx_line(bridge_serial_in));
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    sof <= sof_en & ~sof;
    cyc <= cyc + 1;
    drops <= drops + (rx_overrun === 1'b1);
    if (cyc == 90000)
    begin
      err_total++;
      finish_test();
    end
  end
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd8
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One driver for both byte streams keeps the hold-until-taken rule in one place
  task automatic put(input logic ov, input logic [7:0] d, input logic l);
    @(posedge clk);
    if (ov)
      {ovr_valid, ovr_data, ovr_last} <= {1'b1, d, l};
    else
      {h2t_valid, h2t_data, h2t_last} <= {1'b1, d, l};
    do
    begin
      @(posedge clk);
      stalls += (!ov && h2t_ready !== 1'b1);
    end
    while ((ov ? ovr_ready : h2t_ready) !== 1'b1);
    {ovr_valid, h2t_valid} <= 2'b00;
  endtask : put
  task automatic send_text(input string s);
    for (int i = 0; i < s.len(); i++)
      put(1'b1, s[i], 1'b0);
  endtask : send_text
  // Quiet window afterwards catches characters that should not have been sent
  task automatic drain_check();
    for (int k = 0; k < 30000 && i_tgt.got_q.size() < exp_q.size(); k++)
      @(posedge clk);
    repeat (1000) @(posedge clk);
    check(i_tgt.got_q.size(), exp_q.size());
    while (exp_q.size() > 0 && i_tgt.got_q.size() > 0)
      check(i_tgt.got_q.pop_front(), exp_q.pop_front());
    i_tgt.got_q.delete();
    exp_q.delete();
  endtask : drain_check
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (4) @(posedge clk);
    {rst, dtr, t2h_ready} <= 3'b011;
    for (int f = 0; f < 6; f++)
    begin
      n = rnd8() % 3 + 1;
      for (int i = 0; i < n; i++)
      begin
        b = rnd8();
        exp_q.push_back(b);
        put(1'b0, b, i == n - 1);
      end
    end
    check(stalls > 0, 1'b1);
    drain_check();
    dtr <= 1'b0;
    repeat (3) @(posedge clk);
    check(h2t_ready, 1'b0);
    dtr <= 1'b1;
    // Last pass: newer default command must ignore the session rate
    for (int r = 0; r < 4; r++)
    begin
      ovr_legacy <= (r == 2);
      bit_cyc = r == 0 ? DIV_460800 : r == 1 ? DIV_115200 : r == 2 ? 16'h0028 : DIV_9600;
      case (r)
        0: send_text("CMD:SEND_460800=");
        1: send_text("CMD:SEND_115200=");
        default: send_text("CMD:SEND_UART=");
      endcase
      check({ovr_busy, h2t_ready}, 2'b10);
      for (int i = 0; i < (r == 2 ? 52 : r == 3 ? 1 : 2); i++)
      begin
        b = rnd8() | 8'h01;
        if (i < 50)
          exp_q.push_back(b);
        put(1'b1, b, r == 2 && i == 51);
      end
      if (r != 2)
        put(1'b1, NUL_CHAR, 1'b0);
      if (r != 2)
        put(1'b1, 8'h5A, 1'b1);
      drain_check();
    end
    bit_cyc = 16'h0028;
    // Too short a bit period; the clamp must keep breaks at full length
    cfg_bit_cycles <= 16'h0010;
    // Breaks only once the queues are drained and no file is in progress
    for (int r = 0; r < 3; r++)
    begin
      brk_ms <= r == 0 ? 16'h0000 : r == 1 ? 16'hEA60 : BRK_INDEF;
      brk_start <= 1'b1;
      @(posedge clk);
      brk_start <= 1'b0;
      n = 0;
      for (int k = 0; k < 4000 && (brk_active !== 1'b0 || n == 0); k++)
      begin
        @(posedge clk);
        n += (brk_active === 1'b1);
        brk_release <= (r == 2 && n == 1000);
      end
      lo = r == 0 ? int'(BRK_BITS) * int'(BIT_CYC_MIN) : r == 1 ? int'(BRK_BITS) * 200 : 1001;
      check(n >= lo && n <= lo + 3, 1'b1);
      repeat (100) @(posedge clk);
    end
    cfg_bit_cycles <= 16'h0028;
    check(i_tgt.got_q.size(), 0);
    t2h_ready <= 1'b0;
    sof_en <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      b = rnd8();
      if (exp_q.size() < 8)
        exp_q.push_back(b);
      i_tgt.send_byte(b);
    end
    repeat (400) @(posedge clk);
    check(drops, 9 - exp_q.size());
    t2h_ready <= 1'b1;
    for (int k = 0; k < 3000 && exp_q.size() > 0; k++)
    begin
      @(posedge clk);
      if (t2h_valid === 1'b1)
      begin
        check(t2h_data, exp_q.pop_front());
        check(t2h_last, 1'b1);
      end
    end
    check(exp_q.size(), 0);
    finish_test();
  end
endmodule : testbench
